//--- logic/dsp_decoder_consts.svh
// field positions, codes, widths and reset values of the instruction decoder
`ifndef DSP_DECODER_CONSTS_SVH
`define DSP_DECODER_CONSTS_SVH
`define WORD_W        16
`define INSTR_W       23
`define PC_W          11
`define DP_W          7
`define RP_W          9
`define PROD_W        32
`define STACK_DEPTH   4
`define OPC_MSB       22
`define OPC_LSB       21
`define ALU_MSB       18
`define ALU_LSB       15
`define ASL_BIT       14
`define DPL_MSB       13
`define DPL_LSB       12
`define DPH_MSB       11
`define DPH_LSB       9
`define RPDEC_BIT     8
`define SRC_MSB       7
`define SRC_LSB       4
`define DST_MSB       3
`define DST_LSB       0
`define BRANCH_TYPE_FIELD_MSB      20
`define BRANCH_TYPE_FIELD_LSB      18
`define CND_MSB       17
`define CND_LSB       13
`define NA_MSB        12
`define NA_LSB        2
`define IMM_MSB       20
`define IMM_LSB       5
`define HIRAM_BIT     6
`define OP_ARITH      2'h0
`define OP_RETURN     2'h1
`define OP_BRANCH     2'h2
`define OP_LOADI      2'h3
`define BR_JUMP       3'h4
`define BR_CALL       3'h5
`define BR_COND       3'h2
`define DPL_INC       2'h1
`define DPL_DEC       2'h2
`define DPL_CLR       2'h3
`define COND_DPL      4'hC
`define DPL_ZERO      4'h0
`define DPL_FULL      4'hF
`define PC_RESET      11'h000
`define INSTR_PHASES  4
`endif

//--- logic/dsp_decoder_pkg.sv
// types shared by the instruction decoder modules
`default_nettype none
package dsp_decoder_pkg;
    typedef enum logic [3:0] {
        PH1 = 4'h1, PH2 = 4'h2, PH3 = 4'h4, PH4 = 4'h8
    } phase_type;
    typedef enum logic [3:0] {
        SRC_NONE = 4'h0, SRC_ACC_A = 4'h1, SRC_ACC_B = 4'h2, SRC_TEMP = 4'h3,
        SRC_DP = 4'h4, SRC_RP = 4'h5, SRC_ROM_OUT = 4'h6, SRC_SIGN = 4'h7,
        SRC_DR = 4'h8, SRC_DR_NOFLAG = 4'h9, SRC_SR = 4'hA, SRC_SI_MSB = 4'hB,
        SRC_SI_LSB = 4'hC, SRC_K = 4'hD, SRC_L = 4'hE, SRC_RAM = 4'hF
    } src_type;
    typedef enum logic [3:0] {
        DST_NONE = 4'h0, DST_ACC_A = 4'h1, DST_ACC_B = 4'h2, DST_TEMP = 4'h3,
        DST_DP = 4'h4, DST_RP = 4'h5, DST_DR = 4'h6, DST_SR = 4'h7,
        DST_SO_LSB = 4'h8, DST_SO_MSB = 4'h9, DST_K = 4'hA, DST_K_ROM_L = 4'hB,
        DST_HIRAM_K = 4'hC, DST_L = 4'hD, DST_NONE_ALT = 4'hE, DST_RAM = 4'hF
    } dst_type;
endpackage
`default_nettype wire

//--- logic/phase_sequencer.sv
// four-phase instruction clock sequencer, one phase per enabled clock
`default_nettype none
module phase_sequencer (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    output dsp_decoder_pkg::phase_type phase_reg
);
    import dsp_decoder_pkg::*;

    phase_type phase_next;

    // rotation 3-4-1-2; an illegal code falls back to the instruction start
    always_comb begin
        unique case (phase_reg)
            PH3:     phase_next = PH4;
            PH4:     phase_next = PH1;
            PH1:     phase_next = PH2;
            PH2:     phase_next = PH3;
            default: phase_next = PH3;
        endcase
    end

    // reset lands on phase 3 so the first word is latched at once
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_reg <= PH3;
        end else if (clk_en) begin
            phase_reg <= phase_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    phase_rotation_a: assert property (clk_en && phase_reg == PH3 |=> phase_reg == PH4)
        else $error("phase 3 not followed by phase 4");
    phase_hold_a: assert property (!clk_en |=> $stable(phase_reg))
        else $error("phase moved while clock enable low");
endmodule
`default_nettype wire

//--- logic/operand_multiplier.sv
// signed operand multiplier, product one instruction after capture
`default_nettype none
`include "dsp_decoder_consts.svh"
module operand_multiplier (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic                 capture,
    input  wire logic [`WORD_W-1:0]   k_value,
    input  wire logic [`WORD_W-1:0]   l_value,
    output logic      [`PROD_W-1:0]   product_reg
);
    logic [`WORD_W-1:0] k_cap_reg;
    logic [`WORD_W-1:0] l_cap_reg;
    logic [`PROD_W-1:0] product_next;

    assign product_next = $signed(k_cap_reg) * $signed(l_cap_reg);

    // operands taken at phase 1, the earlier pair's product shown at the same edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            k_cap_reg   <= '0;
            l_cap_reg   <= '0;
            product_reg <= '0;
        end else if (clk_en && capture) begin
            k_cap_reg   <= k_value;
            l_cap_reg   <= l_value;
            product_reg <= product_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    product_latency_a: assert property (clk_en && capture
        |=> product_reg == $past(product_next))
        else $error("product not shown at following capture");
endmodule
`default_nettype wire

//--- logic/dsp_instruction_decoder.sv
// instruction decode, internal bus, branch sequencing and register moves
`default_nettype none
`include "dsp_decoder_consts.svh"
module dsp_instruction_decoder (
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    input  wire logic [`INSTR_W-1:0]    rom_word,
    input  wire logic [`WORD_W-1:0]     data_rom_word,
    input  wire logic [`WORD_W-1:0]     alu_result,
    input  wire logic [11:0]            alu_flags,
    input  wire logic [`WORD_W-1:0]     sign_value,
    input  wire logic [`WORD_W-1:0]     si_word,
    input  wire logic                   si_ack,
    input  wire logic                   so_ack,
    input  wire logic [`WORD_W-1:0]     host_data_in,
    input  wire logic                   host_write,
    input  wire logic                   host_read,
    input  wire logic                   dma_mode,
    output logic      [`PC_W-1:0]       rom_addr_reg,
    output logic      [`RP_W-1:0]       rom_pointer,
    output logic      [`DP_W-1:0]       ram_data_pointer,
    output logic      [`WORD_W-1:0]     acc_a_reg,
    output logic      [`WORD_W-1:0]     acc_b_reg,
    output logic      [`WORD_W-1:0]     alu_operand_reg,
    output logic      [3:0]             alu_func_reg,
    output logic                        alu_acc_b_reg,
    output logic      [`WORD_W-1:0]     host_data_register,
    output logic      [`WORD_W-1:0]     host_status_register,
    output logic                        host_request_flag,
    output logic                        dma_request_out,
    output logic      [`WORD_W-1:0]     so_data_reg,
    output logic                        so_load_reg,
    output dsp_decoder_pkg::phase_type  phase_reg,
    output logic      [`PROD_W-1:0]     product_reg
);
    import dsp_decoder_pkg::*;

    logic [`INSTR_W-1:0] instr_reg;
    logic [`WORD_W-1:0]  temp_register;
    logic [`WORD_W-1:0]  k_reg;
    logic [`WORD_W-1:0]  l_reg;
    logic [`WORD_W-1:0]  ram_mem [0:(1<<`DP_W)-1];
    logic [`PC_W-1:0]    stack_mem [0:`STACK_DEPTH-1];
    logic [1:0]          sp_reg;
    logic [`WORD_W-1:0]  src_value;

    function automatic logic [`WORD_W-1:0] bit_reverse(input logic [`WORD_W-1:0] v);
        logic [`WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < `WORD_W; i++) begin
            r[i] = v[`WORD_W-1-i];
        end
        return r;
    endfunction

    // phase strobes, each one clock wide
    wire at_latch = clk_en && phase_reg == PH3;
    wire at_alu   = clk_en && phase_reg == PH1;
    wire at_end   = clk_en && phase_reg == PH2;

    // instruction class and fields
    wire [1:0] opcode    = instr_reg[`OPC_MSB:`OPC_LSB];
    wire       is_move   = opcode == `OP_ARITH || opcode == `OP_RETURN;
    wire       is_return = opcode == `OP_RETURN;
    wire       is_branch = opcode == `OP_BRANCH;
    wire       is_ldi    = opcode == `OP_LOADI;
    wire [2:0] branch_type_field      = instr_reg[`BRANCH_TYPE_FIELD_MSB:`BRANCH_TYPE_FIELD_LSB];
    wire [3:0] cnd_test  = instr_reg[`CND_MSB:`CND_LSB+1];
    wire       cnd_pol   = instr_reg[`CND_LSB];
    wire [`PC_W-1:0]   next_addr = instr_reg[`NA_MSB:`NA_LSB];
    wire [`WORD_W-1:0] immediate = instr_reg[`IMM_MSB:`IMM_LSB];
    wire [2:0] dph_mask  = instr_reg[`DPH_MSB:`DPH_LSB];
    wire [1:0] dpl_op    = instr_reg[`DPL_MSB:`DPL_LSB];
    wire src_type src_sel = is_move ? src_type'(instr_reg[`SRC_MSB:`SRC_LSB]) : SRC_NONE;
    wire dst_type dst_sel = (is_move || is_ldi) ?
        dst_type'(instr_reg[`DST_MSB:`DST_LSB]) : DST_NONE;

    // ram ports: plain pointer and high half for the combined load
    wire [`DP_W-1:0]   hiram_addr = {1'b1, ram_data_pointer[`HIRAM_BIT-1:0]};
    wire [`WORD_W-1:0] ram_rd     = ram_mem[ram_data_pointer];
    wire [`WORD_W-1:0] hiram_rd   = ram_mem[hiram_addr];

    // bus driver; the none code drives zero rather than a stale value
    always_comb begin
        unique case (src_sel)
            SRC_NONE:      src_value = '0;
            SRC_ACC_A:     src_value = acc_a_reg;
            SRC_ACC_B:     src_value = acc_b_reg;
            SRC_TEMP:      src_value = temp_register;
            SRC_DP:        src_value = {{(`WORD_W-`DP_W){1'b0}}, ram_data_pointer};
            SRC_RP:        src_value = {{(`WORD_W-`RP_W){1'b0}}, rom_pointer};
            SRC_ROM_OUT:   src_value = data_rom_word;
            SRC_SIGN:      src_value = sign_value;
            SRC_DR:        src_value = host_data_register;
            SRC_DR_NOFLAG: src_value = host_data_register;
            SRC_SR:        src_value = host_status_register;
            SRC_SI_MSB:    src_value = si_word;
            SRC_SI_LSB:    src_value = bit_reverse(si_word);
            SRC_K:         src_value = k_reg;
            SRC_L:         src_value = l_reg;
            SRC_RAM:       src_value = ram_rd;
        endcase
    end
    // resolved from the latched word during phase 4
    wire [`WORD_W-1:0] internal_bus = is_ldi ? immediate : src_value;

    // branch condition: pairs of tests, bit 0 picks the polarity
    wire [15:0] flag_vec = {host_request_flag, so_ack, si_ack, 1'b0, alu_flags};
    wire dpl_hit   = cnd_pol ? ram_data_pointer[3:0] == `DPL_FULL
                             : ram_data_pointer[3:0] == `DPL_ZERO;
    wire cond_true = (cnd_test == `COND_DPL) ? dpl_hit
                   : flag_vec[cnd_test] == cnd_pol;
    // undefined encodings simply fall through to the next word
    wire is_call   = is_branch && branch_type_field == `BR_CALL;
    wire taken     = is_branch && (branch_type_field == `BR_JUMP || is_call ||
                     (branch_type_field == `BR_COND && cond_true));
    wire [`PC_W-1:0] pc_plus_one = rom_addr_reg + `PC_W'(1);
    wire [`PC_W-1:0] stack_top   = stack_mem[sp_reg - 2'h1];
    wire [`PC_W-1:0] pc_next     = is_return ? stack_top : taken ? next_addr : pc_plus_one;

    // pointer updates; a direct bus write wins over the field modify
    wire [3:0] dpl_next = (dpl_op == `DPL_INC) ? ram_data_pointer[3:0] + 4'h1
                        : (dpl_op == `DPL_DEC) ? ram_data_pointer[3:0] - 4'h1
                        : (dpl_op == `DPL_CLR) ? 4'h0 : ram_data_pointer[3:0];
    wire [`DP_W-1:0] dp_next = (dst_sel == DST_DP) ? internal_bus[`DP_W-1:0]
        : is_move ? {ram_data_pointer[6:4] ^ dph_mask, dpl_next}
        : ram_data_pointer;
    wire [`RP_W-1:0] rp_next = (dst_sel == DST_RP) ? internal_bus[`RP_W-1:0]
        : (is_move && instr_reg[`RPDEC_BIT]) ? rom_pointer - `RP_W'(1)
        : rom_pointer;

    // data register traffic; the no-flag source is left out on purpose
    wire dr_touch  = src_sel == SRC_DR || dst_sel == DST_DR;
    wire flag_set  = at_end && dr_touch;
    wire flag_clr  = host_read || host_write;

    phase_sequencer u_phase (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .phase_reg (phase_reg)
    );

    operand_multiplier u_mult (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .clk_en      (clk_en),
        .capture     (at_alu),
        .k_value     (k_reg),
        .l_value     (l_reg),
        .product_reg (product_reg)
    );

    // fetch: the rom address is stable when phase 3 rises
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            instr_reg <= '0;
        end else if (at_latch) begin
            instr_reg <= rom_word;
        end
    end

    // sequencing at the end of phase 2
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rom_addr_reg <= `PC_RESET;
            sp_reg       <= 2'h0;
        end else if (at_end) begin
            rom_addr_reg <= pc_next;
            if (is_call) begin
                sp_reg <= sp_reg + 2'h1;
            end else if (is_return) begin
                sp_reg <= sp_reg - 2'h1;
            end
        end
    end

    // stack has no reset; a fifth call overwrites the oldest entry
    always_ff @(posedge ref_clk) begin
        if (!reset && at_end && is_call) begin
            stack_mem[sp_reg] <= pc_plus_one;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ram_data_pointer <= '0;
            rom_pointer      <= '0;
        end else if (at_end) begin
            ram_data_pointer <= dp_next;
            rom_pointer      <= rp_next;
        end
    end

    // alu operand latch at phase 1, accumulator latch at phase 3
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alu_operand_reg <= '0;
            alu_func_reg    <= 4'h0;
            alu_acc_b_reg   <= 1'b0;
        end else if (at_alu) begin
            alu_operand_reg <= internal_bus;
            alu_func_reg    <= is_move ? instr_reg[`ALU_MSB:`ALU_LSB] : 4'h0;
            alu_acc_b_reg   <= instr_reg[`ASL_BIT];
        end
    end

    wire alu_wr = at_latch && alu_func_reg != 4'h0;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_a_reg <= '0;
            acc_b_reg <= '0;
        end else if (alu_wr) begin
            if (alu_acc_b_reg) begin
                acc_b_reg <= alu_result;
            end else begin
                acc_a_reg <= alu_result;
            end
        end else if (at_end) begin
            if (dst_sel == DST_ACC_A) acc_a_reg <= internal_bus;
            if (dst_sel == DST_ACC_B) acc_b_reg <= internal_bus;
        end
    end

    // bus receivers, with k also loaded from high ram and l from the data rom; the two none codes fall through untouched
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            temp_register        <= '0;
            host_status_register <= '0;
            k_reg                <= '0;
            l_reg                <= '0;
        end else if (at_end) begin
            if (dst_sel == DST_TEMP) temp_register <= internal_bus;
            if (dst_sel == DST_SR) host_status_register <= internal_bus;
            if (dst_sel == DST_K || dst_sel == DST_K_ROM_L) k_reg <= internal_bus;
            if (dst_sel == DST_HIRAM_K) k_reg <= hiram_rd;
            if (dst_sel == DST_K_ROM_L) l_reg <= data_rom_word;
            if (dst_sel == DST_L || dst_sel == DST_HIRAM_K) l_reg <= internal_bus;
        end
    end

    // serial out held in msb-first shift order for the shifter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            so_data_reg <= '0;
            so_load_reg <= 1'b0;
        end else if (clk_en) begin
            so_load_reg <= at_end && (dst_sel == DST_SO_LSB || dst_sel == DST_SO_MSB);
            if (at_end && dst_sel == DST_SO_LSB) so_data_reg <= bit_reverse(internal_bus);
            if (at_end && dst_sel == DST_SO_MSB) so_data_reg <= internal_bus;
        end
    end

    // host data register; a program write wins over a same-cycle host write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_data_register <= '0;
        end else if (at_end && dst_sel == DST_DR) begin
            host_data_register <= internal_bus;
        end else if (clk_en && host_write) begin
            host_data_register <= host_data_in;
        end
    end

    // request flag and dma request: a set in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_request_flag <= 1'b0;
            dma_request_out   <= 1'b0;
        end else if (clk_en) begin
            if (flag_set) begin
                host_request_flag <= 1'b1;
                dma_request_out   <= dma_mode;
            end else if (flag_clr) begin
                host_request_flag <= 1'b0;
                dma_request_out   <= 1'b0;
            end
        end
    end

    // data ram has no reset
    always_ff @(posedge ref_clk) begin
        if (!reset && at_end && dst_sel == DST_RAM) begin
            ram_mem[ram_data_pointer] <= internal_bus;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    dp_mask_xor_a: assert property (at_end && is_move && dst_sel != DST_DP
        |=> ram_data_pointer[6:4] == $past(ram_data_pointer[6:4] ^ dph_mask))
        else $error("high pointer bits not xored with mask");
    rp_decrement_a: assert property (at_end && is_move && instr_reg[`RPDEC_BIT]
        && dst_sel != DST_RP |=> rom_pointer == $past(rom_pointer) - `RP_W'(1))
        else $error("rom pointer not decremented");
    bus_idle_a: assert property (!is_ldi && src_sel == SRC_NONE |-> internal_bus == '0)
        else $error("bus driven with no source");
    si_reverse_a: assert property (src_sel == SRC_SI_LSB
        |-> internal_bus[0] == si_word[`WORD_W-1] && internal_bus[`WORD_W-1] == si_word[0])
        else $error("lsb-first serial read not reversed");
    noflag_quiet_a: assert property (at_end && src_sel == SRC_DR_NOFLAG && dst_sel != DST_DR
        && !host_request_flag |=> !host_request_flag && !dma_request_out)
        else $error("no-flag read raised a request");
    flag_set_a: assert property (flag_set |=> host_request_flag ##1
        (host_request_flag || $past(flag_clr)))
        else $error("request flag not set by data register move");
    jump_taken_a: assert property (at_end && is_branch && branch_type_field == `BR_JUMP
        |=> rom_addr_reg == $past(next_addr) && $stable(sp_reg))
        else $error("jump did not load next address");
    cond_fall_a: assert property (at_end && is_branch && branch_type_field == `BR_COND && !cond_true
        |=> rom_addr_reg == $past(rom_addr_reg) + `PC_W'(1))
        else $error("false condition did not advance by one");
    call_push_a: assert property (at_end && is_call
        |=> stack_mem[sp_reg - 2'h1] == $past(rom_addr_reg) + `PC_W'(1))
        else $error("call did not push the following address");
    acc_latch_a: assert property (alu_wr && !alu_acc_b_reg |=> acc_a_reg == $past(alu_result))
        else $error("alu result not latched at phase 3");

    call_seen_c:   cover property (at_end && is_call);
    return_seen_c: cover property (at_end && is_return);
    hiram_load_c:  cover property (at_end && dst_sel == DST_HIRAM_K);
    ldi_seen_c:    cover property (at_end && is_ldi && dst_sel == DST_ACC_A);
endmodule
`default_nettype wire

//--- tb/program_rom.sv
// program rom model that feeds instruction words to the decoder
`default_nettype none
`include "dsp_decoder_consts.svh"
module program_rom (
    input  wire logic [`PC_W-1:0]    rom_addr,
    output logic      [`INSTR_W-1:0] rom_word
);
    // combinational read, as the decoder assumes; empty places give a do-nothing move
    always_comb begin
        case (rom_addr)
            11'h000: rom_word = {2'h3, 16'h8030, 1'h0, 4'h4};
            11'h001: rom_word = {11'h000, 3'h5, 1'h0, 8'h00};
            11'h002: rom_word = {2'h3, 16'h8005, 1'h0, 4'h5};
            11'h003: rom_word = {11'h000, 3'h0, 1'h1, 8'h00};
            11'h004: rom_word = {2'h3, 16'h9ABC, 1'h0, 4'h1};
            11'h005: rom_word = {15'h0000, 8'h16};
            11'h006: rom_word = {15'h0000, 8'hC2};
            11'h007: rom_word = {15'h0000, 8'hB1};
            11'h008: rom_word = {15'h0000, 8'h18};
            11'h009: rom_word = {2'h2, 3'h2, 5'h1F, 11'h014, 2'h0};
            11'h014: rom_word = {2'h2, 3'h5, 5'h00, 11'h01E, 2'h0};
            11'h01E: rom_word = {2'h1, 21'h000000};
            11'h015: rom_word = {2'h2, 3'h4, 5'h00, 11'h015, 2'h0};
            default: rom_word = '0;
        endcase
    end
endmodule
`default_nettype wire

//--- tb/dsp_instruction_decoder_tb.sv
// self-checking bench running a short program through the decoder
`default_nettype none
`include "dsp_decoder_consts.svh"
module dsp_instruction_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                ref_clk = 1'b0;
    logic                reset = 1'b1;
    logic                host_read = 1'b0;
    logic                clk_en = 1'b1, dma_mode = 1'b1, host_write = 1'b0;
    logic [15:0]         si_word = 16'hC1E5;
    logic [15:0]         data_rom_word = 16'h5A3C;
    logic [`INSTR_W-1:0] rom_word;
    logic [`PC_W-1:0]    rom_addr_reg;
    logic [`RP_W-1:0]    rom_pointer;
    logic [`DP_W-1:0]    ram_data_pointer;
    logic [15:0]         acc_a_reg, acc_b_reg, host_data_register, so_data_reg;
    logic                host_request_flag, dma_request_out;
    int                  error_cnt = 0, check_count = 0;

    always #50 ref_clk = ~ref_clk;

    program_rom i_rom (.rom_addr(rom_addr_reg), .rom_word(rom_word));

    dsp_instruction_decoder i_dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .rom_word(rom_word),
        .data_rom_word(data_rom_word), .alu_result(16'h0000), .alu_flags(12'h000),
        .sign_value(16'h0000), .si_word(si_word), .si_ack(1'b0), .so_ack(1'b0),
        .host_data_in(si_word), .host_write(host_write), .host_read(host_read),
        .dma_mode(dma_mode), .rom_addr_reg(rom_addr_reg), .rom_pointer(rom_pointer),
        .ram_data_pointer(ram_data_pointer), .acc_a_reg(acc_a_reg), .acc_b_reg(acc_b_reg),
        .alu_operand_reg(), .alu_func_reg(), .alu_acc_b_reg(),
        .host_data_register(host_data_register), .host_status_register(),
        .host_request_flag(host_request_flag), .dma_request_out(dma_request_out),
        .so_data_reg(so_data_reg), .so_load_reg(), .phase_reg(), .product_reg()
    );

    // bit reversal worked out here, independent of the design
    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) rev16[i] = v[15-i];
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one instruction is four enabled clocks; sample after the closing edge settles
    task automatic step(input string name);
        repeat (`INSTR_PHASES) @(posedge ref_clk);
        #1;
        $display("test %s done", name);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // program order fixes the expectations, one instruction per step
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        step("dp load");
        chk(ram_data_pointer, 7'h30);
        step("dp mask");
        chk(ram_data_pointer, 7'h60);
        step("rp load");
        chk(rom_pointer, 9'h005);
        step("rp dec");
        chk(rom_pointer, 9'h004);
        step("ldi acc");
        chk(acc_a_reg, 16'h9ABC);
        step("dr move");
        chk(host_data_register, 16'h9ABC);
        chk(host_request_flag, 1'b1);
        chk(dma_request_out, 1'b1);
        step("si lsb");
        chk(acc_b_reg, rev16(si_word));
        step("si msb");
        chk(acc_a_reg, si_word);
        step("so lsb");
        chk(so_data_reg, rev16(si_word));
        step("cond jump");
        chk(rom_addr_reg, 11'h014);
        step("call");
        chk(rom_addr_reg, 11'h01E);
        step("return");
        chk(rom_addr_reg, 11'h015);
        step("jump");
        chk(rom_addr_reg, 11'h015);
        @(posedge ref_clk);
        host_read <= 1'b1;
        @(posedge ref_clk);
        host_read <= 1'b0;
        step("host clear");
        chk(host_request_flag, 1'b0);
        conclude();
    end

    // hang guard, counted as a mismatch
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
